/* File: src/fdm_cfg.svh */
// register indices, field positions and reset values of the monitor block
`ifndef FDM_CFG_SVH
`define FDM_CFG_SVH
`define FDM_IDX_THR_LO 10'h249
`define FDM_IDX_THR_HI 10'h24A
`define FDM_IDX_DWELL_LO 10'h24B
`define FDM_IDX_DWELL_HI 10'h24C
`define FDM_IDX_SYNC_CTL 10'h26F
`define FDM_IDX_PER0 10'h271
`define FDM_IDX_PER1 10'h272
`define FDM_IDX_PER2 10'h273
`define FDM_IDX_IRQ_STAT 10'h280
`define FDM_IDX_IRQ_MASK 10'h281
`define FDM_IDX_STATUS 10'h282
`define FDM_IDX_LSB 2
`define FDM_IDX_MSB 11
`define FDM_HTRANS_ACT_BIT 1
`define FDM_RST_BYTE 8'h00
`define FDM_RST_PER0 8'h80
`define FDM_THR_HI_W 5
`define FDM_SYNC_EN_BIT 0
`define FDM_SYNC_NEXT_BIT 1
`define FDM_SYNC_W 2
`define FDM_IRQ_SYNC_BIT 0
`define FDM_IRQ_REL_BIT 1
`define FDM_IRQ_RAISE_BIT 2
`define FDM_IRQ_W 3
`define FDM_ST_ALARM_BIT 0
`define FDM_ST_BELOW_BIT 1
`define FDM_ST_ARMED_BIT 2
`endif

/* File: src/fdm_pkg.sv */
// types shared by the monitor block
package fdm_pkg;
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_RDWAIT = 1'b1
	} fdm_bus_e;
	typedef logic [9:0] fdm_idx_t;
	typedef logic [7:0] fdm_byte_t;
endpackage

/* File: src/fdm_mon_if.sv */
// signals between the register top and the dwell and sync engines
interface fdm_mon_if #(
	parameter int DWELL_W = 16
);
	logic mag_below;
	logic alarm_set;
	logic [DWELL_W-1:0] dwell_value;
	logic alarm;
	logic alarm_released;
	logic sync_en;
	logic sync_next;
	logic sysref;
	logic sync_pulse;
	logic disarm;
	modport ctl(
		output mag_below, alarm_set, dwell_value, sync_en, sync_next, sysref,
		input alarm, alarm_released, sync_pulse, disarm
	);
	modport dwell(
		input mag_below, alarm_set, dwell_value,
		output alarm, alarm_released
	);
	modport sync(
		input sync_en, sync_next, sysref,
		output sync_pulse, disarm
	);
endinterface

/* File: src/fdm_dwell.sv */
// dwell counter that releases the level alarm outputs
module fdm_dwell
	import fdm_pkg::*;
#(
	parameter int DWELL_W = 16
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// engine signals
	fdm_mon_if.dwell mon
);
	logic [DWELL_W-1:0] count_reg;
	logic alarm_reg;
	logic release_now;

	assign release_now = alarm_reg && !mon.alarm_set && mon.mag_below &&
		(count_reg == '0);
	assign mon.alarm = alarm_reg;
	assign mon.alarm_released = release_now;

	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= '0;
		end else if (mon.alarm_set || !mon.mag_below) begin
			count_reg <= mon.dwell_value;
		end else if (count_reg != '0) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	// a new alarm wins over a release in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			alarm_reg <= 1'b0;
		end else if (mon.alarm_set) begin
			alarm_reg <= 1'b1;
		end else if (release_now) begin
			alarm_reg <= 1'b0;
		end
	end
endmodule

/* File: src/fdm_sync.sv */
// sysref edge qualifier for signal monitor synchronisation
module fdm_sync
	import fdm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// engine signals
	fdm_mon_if.sync mon
);
	logic sysref_q_reg;
	logic edge_seen;

	always_ff @(posedge clk) begin
		if (rst) begin
			sysref_q_reg <= 1'b0;
		end else begin
			sysref_q_reg <= mon.sysref;
		end
	end

	assign edge_seen = mon.sysref && !sysref_q_reg;
	assign mon.sync_pulse = mon.sync_en && edge_seen;
	assign mon.disarm = mon.sync_en && mon.sync_next && edge_seen;
endmodule

/* File: src/fdm_top.sv */
// fast-detect dwell and signal monitor sync controller with AHB-Lite regs
// Behaviour
// - 16-bit dwell count must expire below threshold before alarms clear.
// - dwell value built from low byte register and high byte register.
// - sync control bit 1 picks continuous or next-edge-only mode.
// - next-edge mode uses only the first sysref edge after arming.
// - next-edge mode clears the sync enable bit once the edge is taken.
// - sync control bit 0 enables sysref sync, reset value zero.
// - magnitude compared against 13-bit lower threshold to run dwell.
// - monitor period is a 24-bit count of clocks, even values only.
//
// The implementer's own choice: register access over AHB-Lite.
`include "fdm_cfg.svh"

module fdm_top
	import fdm_pkg::*;
#(
	parameter int MAG_W = 13,
	parameter int DWELL_W = 16,
	parameter int PERIOD_W = 24
)(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// converter side
	input wire logic [MAG_W-1:0] MAG,
	input wire logic ALARM_SET,
	input wire logic SYSREF,
	// monitor outputs
	output logic LEVEL_ALARM_OUTPUTS,
	output logic MON_SYNC,
	output logic MON_PERIOD_END,
	output logic IRQ
);
	// bus state
	fdm_bus_e bus_state_reg;
	fdm_bus_e bus_state_next;
	fdm_idx_t addr_reg;
	logic wr_pend_reg;
	fdm_byte_t hrdata_reg;
	fdm_byte_t rd_byte;
	fdm_byte_t wbyte;
	logic addr_ph;

	// software registers
	fdm_byte_t dwell_lo_reg;
	fdm_byte_t dwell_hi_reg;
	fdm_byte_t thr_lo_reg;
	logic [`FDM_THR_HI_W-1:0] thr_hi_reg;
	logic [`FDM_SYNC_W-1:0] sync_ctl_reg;
	fdm_byte_t per0_reg;
	fdm_byte_t per1_reg;
	fdm_byte_t per2_reg;
	logic [`FDM_IRQ_W-1:0] irq_stat_reg;
	logic [`FDM_IRQ_W-1:0] irq_mask_reg;

	// monitor state
	logic [PERIOD_W-1:0] period_cnt_reg;
	logic [PERIOD_W-1:0] period_eff;
	logic [PERIOD_W-1:0] period_last;
	logic period_end_reg;
	logic mon_sync_reg;
	logic [MAG_W-1:0] threshold;
	logic [`FDM_IRQ_W-1:0] irq_events;

	fdm_mon_if #(.DWELL_W(DWELL_W)) mon ();

	function automatic logic wr_hit(fdm_idx_t idx);
		return wr_pend_reg && (addr_reg == idx);
	endfunction

	// ---- bus slave
	assign addr_ph = HSEL && HTRANS[`FDM_HTRANS_ACT_BIT] && HREADY;
	assign wbyte = HWDATA[7:0];

	// the index is kept for the data phase of both reads and writes
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			addr_reg <= '0;
		end else if (addr_ph) begin
			addr_reg <= HADDR[`FDM_IDX_MSB:`FDM_IDX_LSB];
		end
	end

	// a write lands one edge after its address phase, in the data phase
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			wr_pend_reg <= 1'b0;
		end else begin
			wr_pend_reg <= addr_ph && HWRITE;
		end
	end

	// one wait state on reads so a read always sees the settled registers
	always_comb begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			BUS_IDLE: begin
				if (addr_ph && !HWRITE) begin
					bus_state_next = BUS_RDWAIT;
				end
			end
			BUS_RDWAIT: begin
				bus_state_next = BUS_IDLE;
			end
			default: begin
				bus_state_next = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			bus_state_reg <= BUS_IDLE;
		end else begin
			bus_state_reg <= bus_state_next;
		end
	end

	// unmapped indices and reserved bits read as zero
	always_comb begin
		case (addr_reg)
			`FDM_IDX_THR_LO: begin
				rd_byte = thr_lo_reg;
			end
			`FDM_IDX_THR_HI: begin
				rd_byte = fdm_byte_t'(thr_hi_reg);
			end
			`FDM_IDX_DWELL_LO: begin
				rd_byte = dwell_lo_reg;
			end
			`FDM_IDX_DWELL_HI: begin
				rd_byte = dwell_hi_reg;
			end
			`FDM_IDX_SYNC_CTL: begin
				rd_byte = fdm_byte_t'(sync_ctl_reg);
			end
			`FDM_IDX_PER0: begin
				rd_byte = per0_reg;
			end
			`FDM_IDX_PER1: begin
				rd_byte = per1_reg;
			end
			`FDM_IDX_PER2: begin
				rd_byte = per2_reg;
			end
			`FDM_IDX_IRQ_STAT: begin
				rd_byte = fdm_byte_t'(irq_stat_reg);
			end
			`FDM_IDX_IRQ_MASK: begin
				rd_byte = fdm_byte_t'(irq_mask_reg);
			end
			`FDM_IDX_STATUS: begin
				rd_byte = `FDM_RST_BYTE;
				rd_byte[`FDM_ST_ALARM_BIT] = mon.alarm;
				rd_byte[`FDM_ST_BELOW_BIT] = mon.mag_below;
				rd_byte[`FDM_ST_ARMED_BIT] = sync_ctl_reg[`FDM_SYNC_EN_BIT];
			end
			default: begin
				rd_byte = `FDM_RST_BYTE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			hrdata_reg <= `FDM_RST_BYTE;
		end else if (bus_state_reg == BUS_RDWAIT) begin
			hrdata_reg <= rd_byte;
		end
	end

	assign HRDATA = {24'h000000, hrdata_reg};
	// writes never stall; only a read data phase waits
	assign HREADYOUT = (bus_state_reg != BUS_RDWAIT);
	assign HRESP = 1'b0;

	// ---- configuration registers
	// dwell byte registers
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			dwell_lo_reg <= `FDM_RST_BYTE;
			dwell_hi_reg <= `FDM_RST_BYTE;
		end else begin
			if (wr_hit(`FDM_IDX_DWELL_LO)) begin
				dwell_lo_reg <= wbyte;
			end
			if (wr_hit(`FDM_IDX_DWELL_HI)) begin
				dwell_hi_reg <= wbyte;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			thr_lo_reg <= `FDM_RST_BYTE;
			thr_hi_reg <= '0;
		end else begin
			if (wr_hit(`FDM_IDX_THR_LO)) begin
				thr_lo_reg <= wbyte;
			end
			if (wr_hit(`FDM_IDX_THR_HI)) begin
				thr_hi_reg <= wbyte[`FDM_THR_HI_W-1:0];
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			per0_reg <= `FDM_RST_PER0;
			per1_reg <= `FDM_RST_BYTE;
			per2_reg <= `FDM_RST_BYTE;
		end else begin
			if (wr_hit(`FDM_IDX_PER0)) begin
				per0_reg <= wbyte;
			end
			if (wr_hit(`FDM_IDX_PER1)) begin
				per1_reg <= wbyte;
			end
			if (wr_hit(`FDM_IDX_PER2)) begin
				per2_reg <= wbyte;
			end
		end
	end

	// software may re-arm in the very cycle the engine disarms; its write wins
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			sync_ctl_reg <= '0;
		end else if (wr_hit(`FDM_IDX_SYNC_CTL)) begin
			sync_ctl_reg <= wbyte[`FDM_SYNC_W-1:0];
		end else if (mon.disarm) begin
			sync_ctl_reg[`FDM_SYNC_EN_BIT] <= 1'b0;
		end
	end

	// ---- engines
	assign threshold = MAG_W'({thr_hi_reg, thr_lo_reg});
	assign mon.mag_below = (MAG < threshold);
	assign mon.alarm_set = ALARM_SET;
	assign mon.dwell_value = DWELL_W'({dwell_hi_reg, dwell_lo_reg});
	assign mon.sync_en = sync_ctl_reg[`FDM_SYNC_EN_BIT];
	assign mon.sync_next = sync_ctl_reg[`FDM_SYNC_NEXT_BIT];
	// sysref is taken as already synchronous to the core clock
	assign mon.sysref = SYSREF;

	fdm_dwell #(
		.DWELL_W(DWELL_W)
	) u_dwell (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.mon(mon.dwell)
	);

	fdm_sync u_sync (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.mon(mon.sync)
	);

	// ---- monitor period counter
	// odd period values are unsupported, so the low bit is ignored
	assign period_eff = PERIOD_W'({per2_reg, per1_reg, per0_reg[7:1], 1'b0});
	assign period_last = PERIOD_W'(period_eff - 1'b1);

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			period_cnt_reg <= '0;
		end else if (mon.sync_pulse) begin
			period_cnt_reg <= '0;
		// a count left past a shortened period wraps at once
		end else if (period_cnt_reg >= period_last) begin
			period_cnt_reg <= '0;
		end else begin
			period_cnt_reg <= period_cnt_reg + 1'b1;
		end
	end

	// a sync on the last count restarts the period, so no end pulse
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			period_end_reg <= 1'b0;
			mon_sync_reg <= 1'b0;
		end else begin
			period_end_reg <= !mon.sync_pulse &&
				(period_cnt_reg >= period_last);
			mon_sync_reg <= mon.sync_pulse;
		end
	end

	// ---- interrupts
	assign irq_events[`FDM_IRQ_SYNC_BIT] = mon.sync_pulse;
	assign irq_events[`FDM_IRQ_REL_BIT] = mon.alarm_released;
	// raise counts only a fresh alarm, not one already standing
	assign irq_events[`FDM_IRQ_RAISE_BIT] = ALARM_SET && !mon.alarm;

	// an event in the clearing cycle is kept: set wins over write-one-clear
	for (genvar i = 0; i < `FDM_IRQ_W; i++) begin : g_irq
		always_ff @(posedge CORE_CLK) begin
			if (SYS_RST) begin
				irq_stat_reg[i] <= 1'b0;
			end else if (irq_events[i]) begin
				irq_stat_reg[i] <= 1'b1;
			end else if (wr_hit(`FDM_IDX_IRQ_STAT) && wbyte[i]) begin
				irq_stat_reg[i] <= 1'b0;
			end
		end
	end

	// mask has the status layout; the interrupt is a plain level
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			irq_mask_reg <= '0;
		end else if (wr_hit(`FDM_IDX_IRQ_MASK)) begin
			irq_mask_reg <= wbyte[`FDM_IRQ_W-1:0];
		end
	end

	// ---- outputs
	// alarm pins follow engine
	assign LEVEL_ALARM_OUTPUTS = mon.alarm;
	assign MON_SYNC = mon_sync_reg;
	assign MON_PERIOD_END = period_end_reg;
	assign IRQ = |(irq_stat_reg & irq_mask_reg);
endmodule

/* File: testbench/fdm_top_properties.sv */
// concurrent checks on the monitor block ports
module fdm_top_properties (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// bus
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	// monitor
	input wire logic ALARM_SET,
	input wire logic SYSREF,
	input wire logic LEVEL_ALARM_OUTPUTS,
	input wire logic MON_SYNC,
	input wire logic MON_PERIOD_END
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);
	logic take;
	assign take = HSEL && HTRANS[1] && HREADY;
	property p_rd;
		take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
	endproperty
	a_rd: assert property (p_rd)
		else $error("read wait state wrong");
	property p_wr;
		take && HWRITE |=> HREADYOUT;
	endproperty
	a_wr: assert property (p_wr)
		else $error("write stalled");
	property p_resp;
		!HRESP;
	endproperty
	a_resp: assert property (p_resp)
		else $error("response not okay");
	property p_fall;
		$fell(LEVEL_ALARM_OUTPUTS) |-> !$past(ALARM_SET);
	endproperty
	a_fall: assert property (p_fall)
		else $error("alarm released while set");
	property p_set;
		ALARM_SET |=> LEVEL_ALARM_OUTPUTS;
	endproperty
	a_set: assert property (p_set)
		else $error("alarm not raised");
	property p_rise;
		$rose(LEVEL_ALARM_OUTPUTS) |-> $past(ALARM_SET);
	endproperty
	a_rise: assert property (p_rise)
		else $error("alarm raised without cause");
	property p_cause;
		MON_SYNC |-> $past(SYSREF) && !$past(SYSREF, 2);
	endproperty
	a_cause: assert property (p_cause)
		else $error("sync without sysref edge");
	property p_pulse;
		MON_SYNC |=> !MON_SYNC;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("sync pulse too long");
	property p_pend;
		MON_PERIOD_END |=> !MON_PERIOD_END;
	endproperty
	a_pend: assert property (p_pend)
		else $error("period end pulse too long");
	property p_excl;
		MON_SYNC |-> !MON_PERIOD_END;
	endproperty
	a_excl: assert property (p_excl)
		else $error("period end on a sync edge");
	c_sync: cover property (MON_SYNC);
	c_pend: cover property (MON_PERIOD_END);
	c_rel: cover property ($fell(LEVEL_ALARM_OUTPUTS));
	c_rd: cover property (take && !HWRITE);
endmodule

bind fdm_top fdm_top_properties i_chk(.CORE_CLK(CORE_CLK),
	.SYS_RST(SYS_RST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.ALARM_SET(ALARM_SET), .SYSREF(SYSREF),
	.LEVEL_ALARM_OUTPUTS(LEVEL_ALARM_OUTPUTS), .MON_SYNC(MON_SYNC),
	.MON_PERIOD_END(MON_PERIOD_END));

/* File: testbench/fdm_sysref_src.sv */
// sysref timing source model for the monitor sync tests
module fdm_sysref_src (
	// clock
	input wire logic clk,
	// control
	input wire logic run,
	// sysref line
	output logic sysref
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_reg;
	// period multiple
	// edge every eight clocks, a multiple of the monitor period in use
	always_ff @(posedge clk) begin
		if (run) begin
			cnt_reg <= cnt_reg + 3'h1;
		end else begin
			cnt_reg <= 3'h0;
		end
	end
	// line rests low while stopped, so no stale edge leaks into a test
	assign sysref = run && cnt_reg[2];
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the dwell and monitor sync block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, hsel, hwrite, aset, run, rdy, hresp;
	logic alarm, msync, pend, irq, sysref;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [12:0] mag;
	int errors = 0;
	int checks_done = 0;
	int n_sync = 0;
	int n_pend = 0;
	fdm_top i_dut(.CORE_CLK(clk), .SYS_RST(rst), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata), .HREADYOUT(rdy),
		.HRESP(hresp), .MAG(mag), .ALARM_SET(aset), .SYSREF(sysref),
		.LEVEL_ALARM_OUTPUTS(alarm), .MON_SYNC(msync),
		.MON_PERIOD_END(pend), .IRQ(irq));
	fdm_sysref_src i_src(.clk(clk), .run(run), .sysref(sysref));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (msync === 1'b1) begin
			n_sync <= n_sync + 1;
		end
		if (pend === 1'b1) begin
			n_pend <= n_pend + 1;
		end
	end
	task end_of_test;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			$display("mismatch at %0t: bus timeout", $time);
			end_of_test;
		end
	endtask
	task bus(input logic w, input logic [31:0] a, d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rdv = hrdata;
	endtask
	task wr(input logic [31:0] a, d);
		bus(1'b1, a, d);
	endtask
	task rc(input logic [31:0] a, exp);
		bus(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask
	task t_regs;
		rc(32'h92C, 32'h0);
		rc(32'h930, 32'h0);
		rc(32'h9BC, 32'h0);
		wr(32'h92C, 32'h34);
		wr(32'h930, 32'h12);
		rc(32'h92C, 32'h34);
		rc(32'h930, 32'h12);
		wr(32'h9BC, 32'hFF);
		rc(32'h9BC, 32'h3);
		rc(32'hFFC, 32'h0);
		wr(32'h9BC, 32'h0);
	endtask
	task t_dwell;
		wr(32'h924, 32'h10);
		wr(32'h92C, 32'h03);
		wr(32'h930, 32'h00);
		wr(32'hA04, 32'h02);
		mag <= 13'h20;
		aset <= 1'b1;
		tk(1);
		aset <= 1'b0;
		mag <= 13'h5;
		tk(2);
		chk(irq, 1'b0);
		// magnitude equal to the threshold is not below it
		mag <= 13'h10;
		tk(1);
		mag <= 13'h5;
		tk(4);
		chk(alarm, 1'b1);
		tk(1);
		chk(alarm, 1'b0);
		chk(irq, 1'b1);
		wr(32'hA00, 32'h06);
		tk(1);
		chk(irq, 1'b0);
	endtask
	task t_sync(input logic [31:0] ctl, cnt, ctl_after);
		int s;
		wr(32'h9BC, ctl);
		s = n_sync;
		run <= 1'b1;
		tk(40);
		run <= 1'b0;
		tk(3);
		chk(32'(n_sync - s), cnt);
		rc(32'h9BC, ctl_after);
	endtask
	task t_period;
		int p;
		p = n_pend;
		tk(40);
		chk(32'(n_pend - p), 32'd5);
	endtask
	task t_reset;
		aset <= 1'b1;
		tk(1);
		aset <= 1'b0;
		rst <= 1'b1;
		tk(2);
		chk(alarm, 1'b0);
		rst <= 1'b0;
		rc(32'h9C4, 32'h80);
		rc(32'h92C, 32'h0);
		rc(32'h9BC, 32'h0);
	endtask
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		mag = 13'h0;
		aset = 1'b0;
		run = 1'b0;
		tk(2);
		rst <= 1'b0;
		t_regs;
		t_dwell;
		wr(32'h9C4, 32'h08);
		t_sync(32'h1, 32'd5, 32'h1);
		t_sync(32'h3, 32'd1, 32'h2);
		t_sync(32'h0, 32'd0, 32'h0);
		t_period;
		t_reset;
		end_of_test;
	end
endmodule
